// *** common/bct_dec_if.sv ***
interface bct_dec_if;
  logic [7:0] opcode;
  bct_pkg::bct_cls_t cls;
  logic [1:0] len;
  logic [2:0] cyc_nt;
  logic [2:0] cyc_tk;
  modport dec (input opcode, output cls, len, cyc_nt, cyc_tk);
  modport core (output opcode, input cls, len, cyc_nt, cyc_tk);
endinterface : bct_dec_if

// *** common/bct_pkg.sv ***
package bct_pkg;
  // Instruction classes seen by the sequencer
  typedef enum logic [5:0] {
    CL_OTHER, CL_NOOP, CL_XOR_DI, CL_MOV_DD, CL_MOV_AI, CL_LDPTR,
    CL_CODE_P, CL_CODE_PC, CL_EXT_RD, CL_EXT_WR, CL_EXT_PRD, CL_EXT_PWR,
    CL_STACK, CL_NIB, CL_BOOL, CL_JCY, CL_JNCY, CL_JAZ, CL_JANZ,
    CL_JBS, CL_JBN, CL_JBTC, CL_SREL, CL_JIND, CL_CJ_AD, CL_CJ_AI,
    CL_CJ_RI, CL_CJ_II, CL_DJ_R, CL_DJ_D, CL_PAGED, CL_FAR
  } bct_cls_t;
endpackage : bct_pkg

// *** common/bct_regs.svh ***
`ifndef BCT_REGS_SVH
`define BCT_REGS_SVH
// Special function addresses of the pointer bytes
`define BCT_SFR_PTR_LO 8'h82
`define BCT_SFR_PTR_HI 8'h83
`define BCT_PTR_RST 8'h00
`define BCT_SFR_BIT 7
`define BCT_PAGE_LSB 11
// Opcodes that carry an explicit timing
`define BCT_OP_NOOP 8'h00
`define BCT_OP_SPARE 8'hA5
`define BCT_OP_XOR_DI 8'h63
`define BCT_OP_MOV_DD 8'h85
`define BCT_OP_MOV_AI0 8'hE6
`define BCT_OP_MOV_AI1 8'hE7
`define BCT_OP_LDPTR 8'h90
`define BCT_OP_CODE_P 8'h93
`define BCT_OP_CODE_PC 8'h83
`define BCT_OP_EXT_RD0 8'hE2
`define BCT_OP_EXT_RD1 8'hE3
`define BCT_OP_EXT_WR0 8'hF2
`define BCT_OP_EXT_WR1 8'hF3
`define BCT_OP_EXT_PRD 8'hE0
`define BCT_OP_EXT_PWR 8'hF0
`define BCT_OP_PUSH 8'hC0
`define BCT_OP_POP 8'hD0
`define BCT_OP_NIB0 8'hD6
`define BCT_OP_NIB1 8'hD7
`define BCT_OP_AND_C 8'h82
`define BCT_OP_ANDN_C 8'hB0
`define BCT_OP_OR_C 8'h72
`define BCT_OP_ORN_C 8'hA0
`define BCT_OP_BIT_C 8'hA2
`define BCT_OP_C_BIT 8'h92
`define BCT_OP_JCY 8'h40
`define BCT_OP_JNCY 8'h50
`define BCT_OP_JAZ 8'h60
`define BCT_OP_JANZ 8'h70
`define BCT_OP_JBS 8'h20
`define BCT_OP_JBN 8'h30
`define BCT_OP_JBTC 8'h10
`define BCT_OP_SREL 8'h80
`define BCT_OP_JIND 8'h73
`define BCT_OP_CJ_AD 8'hB5
`define BCT_OP_CJ_AI 8'hB4
`define BCT_OP_CJ_II0 8'hB6
`define BCT_OP_CJ_II1 8'hB7
`define BCT_OP_DJ_D 8'hD5
`define BCT_OP_FJMP 8'h02
`define BCT_OP_FCALL 8'h12
// Pattern opcodes: top five bits or low five bits
`define BCT_HI5_CJ_R 5'h17
`define BCT_HI5_DJ_R 5'h1B
`define BCT_LO5_PJMP 5'h01
`define BCT_LO5_PCALL 5'h11
// Lengths and cycle counts
`define BCT_LEN_1 2'd1
`define BCT_LEN_2 2'd2
`define BCT_LEN_3 2'd3
`define BCT_CYC_1 3'd1
`define BCT_CYC_2 3'd2
`define BCT_CYC_3 3'd3
`define BCT_CYC_4 3'd4
`define BCT_CYC_5 3'd5
`endif

// *** design/bct_core.sv ***
`include "bct_regs.svh"
module bct_core (
  input wire logic clk,
  input wire logic arst_n,
  // Instruction offered by the fetch stage
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] instr_pc,
  // Operand values from the datapath
  input wire logic carry_in,
  input wire logic [7:0] acc_in,
  input wire logic bit_in,
  input wire logic [7:0] dir_in,
  input wire logic [7:0] ind_in,
  input wire logic [7:0] reg_in,
  input wire logic [1:0] bank_select_field,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_q,
  // Sequencing
  output logic ready_q,
  output logic busy_q,
  output logic retire_q,
  output logic [1:0] instr_len_q,
  output logic [2:0] instr_cyc_q,
  output bct_pkg::bct_cls_t instr_cls_q,
  // Flow control
  output logic branch_q,
  output logic [15:0] target_q,
  output logic [15:0] next_pc_q,
  // Operand addressing
  output logic [7:0] dir_addr_q,
  output logic dir_is_sfr_q,
  output logic [7:0] reg_addr_q,
  output logic [7:0] ind_addr_q,
  // Memory side effects
  output logic [15:0] code_addr_q,
  output logic [15:0] ext_addr_q,
  output logic ext_rd_q,
  output logic ext_wr_q,
  output logic bit_clr_q,
  output logic [7:0] bit_addr_q,
  output logic [7:0] nib_acc_q,
  output logic [7:0] nib_mem_q,
  output logic [15:0] pointer_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  bct_dec_if dec_bus ();

  assign dec_bus.opcode = opcode;

  bct_decode u_decode (
    .d (dec_bus.dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Branch decision and target

  logic accept;
  logic taken;
  logic is_cond;
  logic [2:0] cyc_sel;
  logic [7:0] rel;
  logic [15:0] next_pc;
  logic [15:0] rel_tgt;
  logic [15:0] ind_tgt;
  logic [7:0] dir_dec;
  logic [7:0] reg_dec;
  logic [7:0] pointer_low_byte_q;
  logic [7:0] pointer_high_byte_q;
  logic [15:0] sixteen_bit_pointer;
  logic [2:0] rem_q;
  logic [2:0] rem_d;

  assign sixteen_bit_pointer = {pointer_high_byte_q, pointer_low_byte_q};

  // Back-to-back issue: taken in the last cycle of the previous one
  assign accept = instr_valid && ready_q;

  // Address of the first byte after this instruction
  assign next_pc = instr_pc + {14'h0000, dec_bus.len};

  // Offset sits in the last byte of the instruction
  assign rel = (dec_bus.len == `BCT_LEN_3) ? operand2 : operand1;
  assign rel_tgt = next_pc + {{8{rel[7]}}, rel};
  assign ind_tgt = sixteen_bit_pointer + {8'h00, acc_in};
  assign dir_dec = dir_in - 8'h01;
  assign reg_dec = reg_in - 8'h01;

  // Condition per class
  always_comb
  begin
    taken = 1'b0;
    is_cond = 1'b1;
    case (dec_bus.cls)
      bct_pkg::CL_JCY: taken = carry_in;
      bct_pkg::CL_JNCY: taken = !carry_in;
      bct_pkg::CL_JAZ: taken = (acc_in == 8'h00);
      bct_pkg::CL_JANZ: taken = (acc_in != 8'h00);
      bct_pkg::CL_JBS: taken = bit_in;
      bct_pkg::CL_JBN: taken = !bit_in;
      bct_pkg::CL_JBTC: taken = bit_in;
      bct_pkg::CL_CJ_AD: taken = (acc_in != dir_in);
      bct_pkg::CL_CJ_II: taken = (ind_in != operand1);
      bct_pkg::CL_CJ_AI: taken = (acc_in != operand1);
      bct_pkg::CL_CJ_RI: taken = (reg_in != operand1);
      bct_pkg::CL_DJ_R: taken = (reg_dec != 8'h00);
      bct_pkg::CL_DJ_D: taken = (dir_dec != 8'h00);
      default:
      begin
        is_cond = 1'b0;
        taken = 1'b0;
      end
    endcase
  end

  // For conditional classes the not-taken count is one below the taken count in the decode table
  assign cyc_sel = taken ? dec_bus.cyc_tk : dec_bus.cyc_nt;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  // Remaining cycles of the instruction in flight
  always_comb
  begin
    if (accept)
      rem_d = cyc_sel;
    else if (rem_q != 3'd0)
      rem_d = rem_q - 3'd1;
    else
      rem_d = 3'd0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rem_q <= 3'd0;
    else
      rem_q <= rem_d;
  end

  // Status flags are decoded from rem_d, so they load on the same edge as the counter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_q <= 1'b1;
      busy_q <= 1'b0;
      retire_q <= 1'b0;
    end
    else
    begin
      ready_q <= (rem_d <= 3'd1);
      busy_q <= (rem_d != 3'd0);
      retire_q <= (rem_d == 3'd1);
    end
  end

  // Length, count and class held for the whole instruction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      instr_len_q <= 2'd0;
      instr_cyc_q <= 3'd0;
      instr_cls_q <= bct_pkg::CL_OTHER;
      next_pc_q <= 16'h0000;
    end
    else if (accept)
    begin
      instr_len_q <= dec_bus.len;
      instr_cyc_q <= cyc_sel;
      instr_cls_q <= dec_bus.cls;
      next_pc_q <= next_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow change

  // Target held until the next accept; branch_q marks a real redirect
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      branch_q <= 1'b0;
      target_q <= 16'h0000;
    end
    else if (accept)
    begin
      branch_q <= taken;
      target_q <= next_pc;
      if (is_cond && taken)
        target_q <= rel_tgt;
      case (dec_bus.cls)
        bct_pkg::CL_SREL:
        begin
          branch_q <= 1'b1;
          target_q <= rel_tgt;
        end
        bct_pkg::CL_JIND:
        begin
          branch_q <= 1'b1;
          target_q <= ind_tgt;
        end
        bct_pkg::CL_PAGED:
        begin
          branch_q <= 1'b1;
          target_q <= {next_pc[15:`BCT_PAGE_LSB], opcode[7:5], operand1};
        end
        bct_pkg::CL_FAR:
        begin
          branch_q <= 1'b1;
          target_q <= {operand1, operand2};
        end
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand addressing

  // Bank base is bank times eight; Ri uses only opcode bit 0
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dir_addr_q <= 8'h00;
      dir_is_sfr_q <= 1'b0;
      reg_addr_q <= 8'h00;
      ind_addr_q <= 8'h00;
    end
    else if (accept)
    begin
      dir_addr_q <= operand1;
      dir_is_sfr_q <= operand1[`BCT_SFR_BIT];
      reg_addr_q <= {3'b000, bank_select_field, opcode[2:0]};
      ind_addr_q <= {3'b000, bank_select_field, 2'b00, opcode[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory side effects

  // Strobes are one cycle, in the first cycle of the instruction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_addr_q <= 16'h0000;
    end
    else
    begin
      ext_rd_q <= accept && (dec_bus.cls == bct_pkg::CL_EXT_RD ||
                             dec_bus.cls == bct_pkg::CL_EXT_PRD);
      ext_wr_q <= accept && (dec_bus.cls == bct_pkg::CL_EXT_WR ||
                             dec_bus.cls == bct_pkg::CL_EXT_PWR);
      if (accept)
        ext_addr_q <= (dec_bus.cls == bct_pkg::CL_EXT_PRD ||
                       dec_bus.cls == bct_pkg::CL_EXT_PWR) ?
                      sixteen_bit_pointer : {8'h00, reg_in};
    end
  end

  // Code byte address: accumulator plus pointer or plus next address
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      code_addr_q <= 16'h0000;
    else if (accept && dec_bus.cls == bct_pkg::CL_CODE_P)
      code_addr_q <= ind_tgt;
    else if (accept && dec_bus.cls == bct_pkg::CL_CODE_PC)
      code_addr_q <= next_pc + {8'h00, acc_in};
  end

  // Test-and-clear only clears a bit that was found set
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_clr_q <= 1'b0;
      bit_addr_q <= 8'h00;
    end
    else
    begin
      bit_clr_q <= accept && dec_bus.cls == bct_pkg::CL_JBTC && bit_in;
      if (accept)
        bit_addr_q <= operand1;
    end
  end

  // High nibbles stay where they are
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nib_acc_q <= 8'h00;
      nib_mem_q <= 8'h00;
    end
    else if (accept && dec_bus.cls == bct_pkg::CL_NIB)
    begin
      nib_acc_q <= {acc_in[7:4], ind_in[3:0]};
      nib_mem_q <= {ind_in[7:4], acc_in[3:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer register pair

  // Instruction load wins over a same-cycle register write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pointer_low_byte_q <= `BCT_PTR_RST;
      pointer_high_byte_q <= `BCT_PTR_RST;
    end
    else if (accept && dec_bus.cls == bct_pkg::CL_LDPTR)
    begin
      pointer_high_byte_q <= operand1;
      pointer_low_byte_q <= operand2;
    end
    else if (sfr_wr && sfr_addr == `BCT_SFR_PTR_LO)
      pointer_low_byte_q <= sfr_wdata;
    else if (sfr_wr && sfr_addr == `BCT_SFR_PTR_HI)
      pointer_high_byte_q <= sfr_wdata;
  end

  // Registered copy so the output comes from a flop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pointer_q <= 16'h0000;
    else
      pointer_q <= sixteen_bit_pointer;
  end

  // Read data one cycle after the strobe; other addresses read zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sfr_rdata_q <= 8'h00;
    else if (sfr_rd && sfr_addr == `BCT_SFR_PTR_LO)
      sfr_rdata_q <= pointer_low_byte_q;
    else if (sfr_rd && sfr_addr == `BCT_SFR_PTR_HI)
      sfr_rdata_q <= pointer_high_byte_q;
    else if (sfr_rd)
      sfr_rdata_q <= 8'h00;
  end

endmodule : bct_core

// *** design/bct_decode.sv ***
`include "bct_regs.svh"
// Opcode to class, length and cycle counts, purely combinational
module bct_decode (
  bct_dec_if.dec d
);
  always_comb
  begin
    d.cls = bct_pkg::CL_OTHER;
    d.len = `BCT_LEN_1;
    d.cyc_nt = `BCT_CYC_1;
    d.cyc_tk = `BCT_CYC_1;
    // Patterned opcodes first, exact ones override below
    if (d.opcode[7:3] == `BCT_HI5_CJ_R)
    begin
      d.cls = bct_pkg::CL_CJ_RI;
      d.len = `BCT_LEN_3;
      d.cyc_nt = `BCT_CYC_3;
      d.cyc_tk = `BCT_CYC_4;
    end
    else if (d.opcode[7:3] == `BCT_HI5_DJ_R)
    begin
      d.cls = bct_pkg::CL_DJ_R;
      d.len = `BCT_LEN_2;
      d.cyc_nt = `BCT_CYC_2;
      d.cyc_tk = `BCT_CYC_3;
    end
    else if (d.opcode[4:0] == `BCT_LO5_PJMP || d.opcode[4:0] == `BCT_LO5_PCALL)
    begin
      d.cls = bct_pkg::CL_PAGED;
      d.len = `BCT_LEN_2;
      d.cyc_nt = `BCT_CYC_3;
      d.cyc_tk = `BCT_CYC_3;
    end
    case (d.opcode)
      `BCT_OP_NOOP, `BCT_OP_SPARE:
      begin
        d.cls = bct_pkg::CL_NOOP;
      end
      `BCT_OP_XOR_DI, `BCT_OP_MOV_DD, `BCT_OP_LDPTR:
      begin
        d.cls = (d.opcode == `BCT_OP_XOR_DI) ? bct_pkg::CL_XOR_DI :
                (d.opcode == `BCT_OP_MOV_DD) ? bct_pkg::CL_MOV_DD : bct_pkg::CL_LDPTR;
        d.len = `BCT_LEN_3;
        d.cyc_nt = `BCT_CYC_3;
        d.cyc_tk = `BCT_CYC_3;
      end
      `BCT_OP_MOV_AI0, `BCT_OP_MOV_AI1, `BCT_OP_NIB0, `BCT_OP_NIB1:
      begin
        d.cls = d.opcode[4] ? bct_pkg::CL_NIB : bct_pkg::CL_MOV_AI;
        d.cyc_nt = `BCT_CYC_2;
        d.cyc_tk = `BCT_CYC_2;
      end
      `BCT_OP_CODE_P, `BCT_OP_CODE_PC, `BCT_OP_EXT_RD0, `BCT_OP_EXT_RD1,
      `BCT_OP_EXT_WR0, `BCT_OP_EXT_WR1, `BCT_OP_EXT_PRD, `BCT_OP_EXT_PWR,
      `BCT_OP_JIND:
      begin
        case (d.opcode)
          `BCT_OP_CODE_P: d.cls = bct_pkg::CL_CODE_P;
          `BCT_OP_CODE_PC: d.cls = bct_pkg::CL_CODE_PC;
          `BCT_OP_EXT_PRD: d.cls = bct_pkg::CL_EXT_PRD;
          `BCT_OP_EXT_PWR: d.cls = bct_pkg::CL_EXT_PWR;
          `BCT_OP_JIND: d.cls = bct_pkg::CL_JIND;
          default: d.cls = d.opcode[4] ? bct_pkg::CL_EXT_WR : bct_pkg::CL_EXT_RD;
        endcase
        d.cyc_nt = `BCT_CYC_3;
        d.cyc_tk = `BCT_CYC_3;
      end
      `BCT_OP_PUSH, `BCT_OP_POP, `BCT_OP_AND_C, `BCT_OP_ANDN_C, `BCT_OP_OR_C,
      `BCT_OP_ORN_C, `BCT_OP_BIT_C, `BCT_OP_C_BIT:
      begin
        d.cls = (d.opcode[6] && d.opcode[7]) ? bct_pkg::CL_STACK : bct_pkg::CL_BOOL;
        d.len = `BCT_LEN_2;
        d.cyc_nt = `BCT_CYC_2;
        d.cyc_tk = `BCT_CYC_2;
      end
      `BCT_OP_JCY, `BCT_OP_JNCY, `BCT_OP_JAZ, `BCT_OP_JANZ:
      begin
        d.cls = (d.opcode == `BCT_OP_JCY) ? bct_pkg::CL_JCY :
                (d.opcode == `BCT_OP_JNCY) ? bct_pkg::CL_JNCY :
                (d.opcode == `BCT_OP_JAZ) ? bct_pkg::CL_JAZ : bct_pkg::CL_JANZ;
        d.len = `BCT_LEN_2;
        d.cyc_nt = `BCT_CYC_2;
        d.cyc_tk = `BCT_CYC_3;
      end
      `BCT_OP_JBS, `BCT_OP_JBN, `BCT_OP_JBTC, `BCT_OP_CJ_AI, `BCT_OP_DJ_D:
      begin
        d.cls = (d.opcode == `BCT_OP_JBS) ? bct_pkg::CL_JBS :
                (d.opcode == `BCT_OP_JBN) ? bct_pkg::CL_JBN :
                (d.opcode == `BCT_OP_JBTC) ? bct_pkg::CL_JBTC :
                (d.opcode == `BCT_OP_CJ_AI) ? bct_pkg::CL_CJ_AI : bct_pkg::CL_DJ_D;
        d.len = `BCT_LEN_3;
        d.cyc_nt = `BCT_CYC_3;
        d.cyc_tk = `BCT_CYC_4;
      end
      `BCT_OP_CJ_AD, `BCT_OP_CJ_II0, `BCT_OP_CJ_II1:
      begin
        d.cls = d.opcode[1] ? bct_pkg::CL_CJ_II : bct_pkg::CL_CJ_AD;
        d.len = `BCT_LEN_3;
        d.cyc_nt = `BCT_CYC_4;
        d.cyc_tk = `BCT_CYC_5;
      end
      `BCT_OP_SREL:
      begin
        d.cls = bct_pkg::CL_SREL;
        d.len = `BCT_LEN_2;
        d.cyc_nt = `BCT_CYC_3;
        d.cyc_tk = `BCT_CYC_3;
      end
      `BCT_OP_FJMP, `BCT_OP_FCALL:
      begin
        d.cls = bct_pkg::CL_FAR;
        d.len = `BCT_LEN_3;
        d.cyc_nt = `BCT_CYC_4;
        d.cyc_tk = `BCT_CYC_4;
      end
      default:
      begin
      end
    endcase
  end
endmodule : bct_decode

// *** verif/bct_core_checker.sv ***
module bct_core_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [15:0] instr_pc,
  input wire logic carry_in,
  input wire logic [1:0] bank_select_field,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic ready_q,
  input wire logic retire_q,
  input wire logic [1:0] instr_len_q,
  input wire logic [2:0] instr_cyc_q,
  input wire logic branch_q,
  input wire logic [15:0] target_q,
  input wire logic [15:0] next_pc_q,
  input wire logic [7:0] dir_addr_q,
  input wire logic dir_is_sfr_q,
  input wire logic [7:0] reg_addr_q,
  input wire logic [7:0] ind_addr_q,
  input wire logic busy_q,
  input wire logic bit_in,
  input wire logic ext_rd_q,
  input wire logic ext_wr_q,
  input wire logic bit_clr_q,
  input wire logic [7:0] bit_addr_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  // Edge at which an instruction is taken
  assign take = instr_valid && ready_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // Timing: the retire pulse must land on the exact cycle
  property p_spare;
    take && opcode == 8'hA5 |=> retire_q && instr_len_q == 2'h1 && instr_cyc_q == 3'h1;
  endproperty
  a_spare: assert property (p_spare) else $error("spare opcode timing");
  property p_xor;
    take && opcode == 8'h63 |=> busy_q && instr_cyc_q == 3'h3 && !retire_q
      ##1 !retire_q ##1 retire_q;
  endproperty
  a_xor: assert property (p_xor) else $error("xor direct timing");
  property p_jc_tk;
    take && opcode == 8'h40 && carry_in |=> (branch_q && !retire_q) [*2] ##1 retire_q;
  endproperty
  a_jc_tk: assert property (p_jc_tk) else $error("taken carry jump timing");
  // Addressing: operands decoded from the bytes of the taken instruction
  property p_rel;
    take && opcode == 8'h80 |=>
      target_q == $past(instr_pc) + 16'h0002 + {{8{$past(operand1[7])}}, $past(operand1)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target");
  property p_dir;
    take |=> dir_addr_q == $past(operand1) && dir_is_sfr_q == $past(operand1[7]);
  endproperty
  a_dir: assert property (p_dir) else $error("direct space select");
  property p_bank;
    take |=> reg_addr_q == {3'h0, $past(bank_select_field), $past(opcode[2:0])}
      && ind_addr_q == {3'h0, $past(bank_select_field), 2'h0, $past(opcode[0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank register address");
  // Both paged forms, jump and call, end in 0001
  property p_paged;
    take && opcode[3:0] == 4'h1 |=> next_pc_q == $past(instr_pc) + 16'h0002
      && target_q == {next_pc_q[15:11], $past(opcode[7:5]), $past(operand1)};
  endproperty
  a_paged: assert property (p_paged) else $error("paged target");
  // Register port: a write is seen by a read on the next cycle
  property p_rdback;
    sfr_wr && sfr_addr == 8'h82 && !(take && opcode == 8'h90)
      ##1 sfr_rd && !sfr_wr && sfr_addr == 8'h82 |=> sfr_rdata_q == $past(sfr_wdata, 2);
  endproperty
  a_rdback: assert property (p_rdback) else $error("pointer low read back");
  // Memory strobes: one cycle only, read or write by opcode bit 4
  property p_ext;
    take && (opcode == 8'hE2 || opcode == 8'hF0) |=> ext_rd_q == !$past(opcode[4])
      && ext_wr_q == $past(opcode[4]) ##1 !ext_rd_q && !ext_wr_q;
  endproperty
  a_ext: assert property (p_ext) else $error("external strobe pulse");
  property p_clr;
    take && opcode == 8'h10 |=> bit_clr_q == $past(bit_in) && bit_addr_q == $past(operand1)
      ##1 !bit_clr_q;
  endproperty
  a_clr: assert property (p_clr) else $error("test and clear request");
endmodule : bct_core_checker
////////////////////////////////////////
bind bct_core bct_core_checker chk_u (
  .clk, .arst_n, .instr_valid, .opcode, .operand1, .instr_pc, .carry_in, .bank_select_field,
  .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q, .ready_q, .retire_q, .instr_len_q,
  .instr_cyc_q, .branch_q, .target_q, .next_pc_q, .dir_addr_q, .dir_is_sfr_q, .reg_addr_q,
  .ind_addr_q, .busy_q, .bit_in, .ext_rd_q, .ext_wr_q, .bit_clr_q, .bit_addr_q
);

// *** verif/bct_core_tb.sv ***
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, a, b); \
    end \
  end
module bct_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic carry_in = 1'b0;
  logic bit_in = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operand1 = 8'h00;
  logic [7:0] operand2 = 8'h00;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [1:0] bank_select_field = 2'h0;
  logic [15:0] instr_pc = 16'h07F0;
  logic [7:0] dir_in, ind_in, reg_in, sfr_rdata_q, dir_addr_q, reg_addr_q, ind_addr_q;
  logic [7:0] bit_addr_q, nib_acc_q, nib_mem_q;
  logic ready_q, busy_q, retire_q, branch_q, dir_is_sfr_q, ext_rd_q, ext_wr_q, bit_clr_q;
  logic [1:0] instr_len_q;
  logic [2:0] instr_cyc_q;
  bct_pkg::bct_cls_t instr_cls_q;
  logic [15:0] target_q, next_pc_q, code_addr_q, ext_addr_q, pointer_q;
  bct_core dut_u (
    .clk, .arst_n, .instr_valid, .opcode, .operand1, .operand2, .instr_pc, .carry_in,
    .acc_in, .bit_in, .dir_in, .ind_in, .reg_in, .bank_select_field, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata_q, .ready_q, .busy_q, .retire_q, .instr_len_q,
    .instr_cyc_q, .instr_cls_q, .branch_q, .target_q, .next_pc_q, .dir_addr_q,
    .dir_is_sfr_q, .reg_addr_q, .ind_addr_q, .code_addr_q, .ext_addr_q, .ext_rd_q,
    .ext_wr_q, .bit_clr_q, .bit_addr_q, .nib_acc_q, .nib_mem_q, .pointer_q
  );
  bct_mem_model mem_u (.opcode, .operand1, .bank_select_field, .dir_in, .ind_in, .reg_in);
  // Free running 20 MHz clock
  always #25 clk = ~clk;
  ////////////////////////////////////////
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // Entry t holds opcode, length and count; one idle cycle before each offer
  task automatic run(input logic [15:0] t, input logic [7:0] o1);
    int k;
    @(negedge clk);
    opcode = t[15:8];
    operand1 = o1;
    operand2 = ~o1;
    instr_valid = 1'b1;
    k = 0;
    while (!ready_q && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    instr_valid = 1'b0;
    k = 1;
    while (retire_q !== 1'b1 && k < 7)
    begin
      @(negedge clk);
      k++;
    end
    `CHK(3'(k), t[2:0])
    `CHK(instr_len_q, t[5:4])
    `CHK(instr_cyc_q, t[2:0])
    instr_pc = instr_pc + 16'(t[5:4]);
  endtask : run
  // Strobes stay up; callers drop them, so back-to-back cycles need no gap
  task automatic special_function_register(input logic wr, input logic [7:0] a, d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = wr;
    sfr_rd = !wr;
    @(negedge clk);
  endtask : special_function_register
  ////////////////////////////////////////
  task automatic t_ptr();
    logic [15:0] pc;
    `CHK(pointer_q, 16'h0000)
    special_function_register(1'b0, 8'h82, 8'h00);
    `CHK(sfr_rdata_q, 8'h00)
    special_function_register(1'b1, 8'h82, 8'hA5);
    special_function_register(1'b0, 8'h82, 8'h00);
    `CHK(sfr_rdata_q, 8'hA5)
    special_function_register(1'b1, 8'h83, 8'h3C);
    special_function_register(1'b1, 8'h84, 8'hFF);
    special_function_register(1'b0, 8'h83, 8'h00);
    `CHK(sfr_rdata_q, 8'h3C)
    special_function_register(1'b0, 8'h84, 8'h00);
    `CHK(sfr_rdata_q, 8'h00)
    `CHK(pointer_q, 16'h3CA5)
    sfr_rd = 1'b0;
    // Second byte is the complement of the first, so the load gives 12ED
    run(16'h9033, 8'h12);
    special_function_register(1'b0, 8'h82, 8'h00);
    `CHK(sfr_rdata_q, 8'hED)
    `CHK(pointer_q, 16'h12ED)
    sfr_rd = 1'b0;
    acc_in = 8'h05;
    run(16'h9313, 8'h00);
    `CHK(code_addr_q, 16'h12F2)
    run(16'hE013, 8'h00);
    `CHK(ext_addr_q, 16'h12ED)
    pc = instr_pc;
    run(16'h8313, 8'h00);
    `CHK(code_addr_q, pc + 16'h0006)
    $display("pointer test done");
  endtask : t_ptr
  task automatic t_timing();
    logic [15:0] tab [31] = '{16'h6333, 16'h8533, 16'hE612, 16'hE712, 16'h9033, 16'h9313,
      16'h8313, 16'hE213, 16'hE313, 16'hF213, 16'hF313, 16'hE013, 16'hF013, 16'hC022,
      16'hD022, 16'hD612, 16'hD712, 16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222,
      16'h9222, 16'h8023, 16'h7313, 16'hA511, 16'h0011, 16'h0123, 16'h1123, 16'h0234, 16'h1234};
    for (int i = 0; i < 31; i++)
    begin
      if (i < 13)
      begin
        run(tab[i], 8'h85);
      end
      else
      begin
        run(tab[i], 8'h85);
      end
    end
    $display("timing test done");
  endtask : t_timing
  // Entry: opcode, first operand, accumulator, carry, bit, length, taken, count
  task automatic t_branch();
    logic [31:0] e;
    logic [15:0] pc;
    logic [7:0] r;
    logic [31:0] tab [25] = '{32'h40FC_0022, 32'h40FC_00AB, 32'h50FC_00A2, 32'h5004_002B,
      32'h6010_0122, 32'h6010_002B, 32'h7010_0022, 32'h7010_802B, 32'h2020_0033,
      32'h2020_007C, 32'h3020_0073, 32'h3020_003C, 32'h1020_007C, 32'h1020_0033,
      32'hB510_4A34, 32'hB510_003D, 32'hB433_3333, 32'hB433_003C, 32'hB85A_0033,
      32'hB800_003C, 32'hB600_0034, 32'hB601_003D, 32'hD8F0_002B, 32'hD55B_0033,
      32'hD510_003C};
    for (int i = 0; i < 25; i++)
    begin
      e = tab[i];
      acc_in = e[15:8];
      carry_in = e[7];
      bit_in = e[6];
      // Offset is the last byte: the complement of the first operand in 3-byte forms
      pc = instr_pc + 16'(e[5:4]);
      r = (e[5:4] == 2'h3) ? ~e[23:16] : e[23:16];
      run({e[31:24], e[7:0]}, e[23:16]);
      pc = e[3] ? pc + {{8{r[7]}}, r} : pc;
      `CHK(branch_q, e[3])
      `CHK(target_q, pc)
    end
    $display("branch test done");
  endtask : t_branch
  task automatic t_bank();
    for (int b = 0; b < 4; b++)
    begin
      bank_select_field = 2'(b);
      run(16'hE213, 8'h00);
      `CHK(ext_addr_q, 16'(b * 8) ^ 16'h005A)
      `CHK(ind_addr_q, 8'(b * 8))
    end
    acc_in = 8'hA7;
    bank_select_field = 2'h1;
    run(16'hD612, 8'h00);
    `CHK(nib_acc_q, 8'hA8)
    `CHK(nib_mem_q, 8'h07)
    `CHK(instr_cls_q, bct_pkg::CL_NIB)
    $display("bank test done");
  endtask : t_bank
  ////////////////////////////////////////
  // Main sequence, reset released on a falling edge
  initial
  begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    t_ptr();
    t_timing();
    t_branch();
    t_bank();
    finish_test();
  end
  // About 70 instructions of at most seven cycles; this span is ample
  initial
  begin
    #(4000 * 50);
    n_mismatch++;
    finish_test();
  end
endmodule : bct_core_tb

// *** verif/bct_mem_model.sv ***
module bct_mem_model (
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [1:0] bank_select_field,
  output logic [7:0] dir_in,
  output logic [7:0] ind_in,
  output logic [7:0] reg_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] reg_sel;
  logic [7:0] ptr_sel;
  // Every RAM byte holds its address xor 5A, so the bench can work out each one
  // Register forms (bit 3 set) use opcode[2:0]; indirect forms use R0 or R1
  always_comb
  begin
    reg_sel = {3'h0, bank_select_field, opcode[3] ? opcode[2:0] : {2'h0, opcode[0]}};
    reg_in = reg_sel ^ 8'h5A;
    ptr_sel = {3'h0, bank_select_field, 2'h0, opcode[0]} ^ 8'h5A;
    ind_in = ptr_sel ^ 8'h5A;
    dir_in = operand1 ^ 8'h5A;
  end
endmodule : bct_mem_model
